// *** src/hfp_pkg.sv ***
// Constants for the host queue ports and their access layer
package hfp_pkg;
   // Widths and depths
   localparam int HFP_DW = 32;
   localparam int HFP_HW = 16;
   localparam int HFP_QDEPTH = 16;
   localparam int HFP_QAW = 4;
   localparam int HFP_LW = 5;
   localparam int HFP_CNTW = 16;

   // Byte offsets on the host bus
   localparam logic [7:0] HFP_RXD_BASE = 8'h00;
   localparam logic [7:0] HFP_TXD_BASE = 8'h20;
   localparam logic [7:0] HFP_RXS_POP = 8'h40;
   localparam logic [7:0] HFP_RXS_PEEK = 8'h44;
   localparam logic [7:0] HFP_TXS_POP = 8'h48;
   localparam logic [7:0] HFP_TXS_PEEK = 8'h4C;
   localparam logic [7:0] HFP_TEST_REG = 8'h50;
   localparam logic [7:0] HFP_CMD_REG = 8'h54;
   localparam logic [7:0] HFP_EVT_REG = 8'h58;
   localparam logic [7:0] HFP_DROP_REG = 8'h5C;
   localparam logic [7:0] HFP_LATCH_REG = 8'h60;
   localparam logic [7:0] HFP_SIZE_REG = 8'h64;
   localparam logic [7:0] HFP_LEVEL_REG = 8'h68;
   // Data ports span eight aliased words each
   localparam logic [2:0] HFP_RXD_WIDX = 3'h0;
   localparam logic [2:0] HFP_TXD_WIDX = 3'h1;

   // Arbitrary test pattern, not tied to any part
   localparam logic [31:0] HFP_TEST_VAL = 32'h5A5A_1234;

   // Command register bits (write only)
   localparam int HFP_CMD_SRST = 0;
   localparam int HFP_CMD_RXFL = 1;
   localparam int HFP_CMD_TXFL = 2;

   // Event register bits (write one to clear)
   localparam int HFP_EVT_RXS_OVF = 0;
   localparam int HFP_EVT_RXD_OVF = 1;
   localparam int HFP_EVT_TXD_OVF = 2;
   localparam int HFP_EVT_UNDER = 3;
   localparam int HFP_EVT_W = 4;

   // Latch register bits
   localparam int HFP_LAT_LINK = 0;
   localparam int HFP_LAT_ERR = 1;

   // Size register field positions and reset values
   localparam int HFP_SZ_RXD = 0;
   localparam int HFP_SZ_TXD = 8;
   localparam int HFP_SZ_RXS = 16;
   localparam logic [4:0] HFP_SZ_RST = 5'h10;

   // Level register field positions
   localparam int HFP_LV_RXD = 0;
   localparam int HFP_LV_TXD = 8;
   localparam int HFP_LV_RXS = 16;
   localparam int HFP_LV_TXS = 24;
endpackage

// *** src/hfp_queue.sv ***
// Flip-flop queue with adjustable capacity and head peek
`timescale 1ns/1ns
module hfp_queue #(
   parameter int W = 32,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_flush,
   input wire logic [AW:0] i_limit,
   input wire logic i_push,
   input wire logic [W-1:0] i_wdata,
   input wire logic i_pop,
   output logic [W-1:0] o_head,
   output logic [AW:0] o_count,
   output logic o_full,
   output logic o_empty
);
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic [AW:0] nxt_count;
   logic [AW:0] eff_limit;
   logic full_ff;
   logic empty_ff;
   logic do_push;
   logic do_pop;

   assign do_push = i_push && !full_ff;
   assign do_pop = i_pop && !empty_ff;
   assign o_head = mem_ff[rd_ptr_ff];
   assign o_count = count_ff;
   assign o_full = full_ff;
   assign o_empty = empty_ff;

   // Zero or oversize limits fall back to the full depth
   always_comb begin
      if (i_limit == '0 || i_limit > (AW+1)'(DEPTH)) begin
         eff_limit = (AW+1)'(DEPTH);
      end else begin
         eff_limit = i_limit;
      end
      nxt_count = count_ff;
      if (do_push && !do_pop) begin
         nxt_count = count_ff + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
         nxt_count = count_ff - (AW+1)'(1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= i_wdata;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst || i_flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         full_ff <= 1'b0;
         empty_ff <= 1'b1;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= wr_ptr_ff + AW'(1);
         end
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + AW'(1);
         end
         count_ff <= nxt_count;
         full_ff <= (nxt_count >= eff_limit);
         empty_ff <= (nxt_count == '0);
      end
   end
endmodule

// *** src/hfp_top.sv ***
// Host access layer: four queue ports and attribute registers
// Behaviour
// - Read-only registers ignore every host write.
// - Write-only registers always read back as zero.
// - Writing one clears a write-one-clear bit; zero leaves it.
// - Clear-on-read bits go to zero when the host reads them, or to one if a drop comes in that cycle.
// - Latch-low and latch-high bits hold until their register is read.
// - Fields kept over soft reset take defaults only on other resets.
// - Reserved addresses return no guaranteed value.
// - Hardware reset (i_rst) loads every configuration register with its default.
// - Four host queues: receive status, receive data, transmit both.
// - Receive data, transmit data, receive status capacities adjustable.
// - Receive status port read returns oldest entry and removes it.
// - Receive status peek read returns oldest entry, keeps it.
// - Every receive data read consumes the data.
// - Receive data decoded at eight identical aliased word addresses.
// - Transmit status port read returns oldest entry and removes it.
// - Transmit status peek read returns oldest entry, keeps it.
// - Transmit data queue is write only, no read path.
// - All eight transmit data aliases push into one queue.
// - Each 32-bit word is built from two 16-bit host transfers.
`timescale 1ns/1ns
module hfp_top (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_host_cs,
   input wire logic i_host_rd,
   input wire logic i_host_wr,
   input wire logic [7:1] i_host_addr,
   input wire logic [hfp_pkg::HFP_HW-1:0] i_host_wdata,
   output logic [hfp_pkg::HFP_HW-1:0] o_host_rdata,
   output logic o_host_rvalid,
   input wire logic i_rxs_push,
   input wire logic [hfp_pkg::HFP_DW-1:0] i_rxs_data,
   output logic o_rxs_full,
   input wire logic i_rxd_push,
   input wire logic [hfp_pkg::HFP_DW-1:0] i_rxd_data,
   output logic o_rxd_full,
   input wire logic i_txs_push,
   input wire logic [hfp_pkg::HFP_DW-1:0] i_txs_data,
   output logic o_txs_full,
   output logic o_txd_valid,
   output logic [hfp_pkg::HFP_DW-1:0] o_txd_data,
   input wire logic i_txd_ready,
   input wire logic i_link_up,
   input wire logic i_err_evt,
   output logic o_soft_rst
);
   import hfp_pkg::*;

   typedef enum {
      HFP_Q_RXS,
      HFP_Q_RXD,
      HFP_Q_TXS,
      HFP_Q_TXD
   } hfp_q_t;
   localparam int NQ = 4;

   logic rd_lo;
   logic rd_hi;
   logic wr_lo;
   logic wr_hi;
   logic [5:0] widx;
   logic in_rxd;
   logic in_txd;
   logic [HFP_DW-1:0] wr_word;
   logic [HFP_DW-1:0] rd_word;
   logic any_rst;

   logic [HFP_HW-1:0] wr_hold_ff;
   logic [HFP_DW-1:0] rd_snap_ff;
   logic soft_rst_ff;
   logic [HFP_EVT_W-1:0] evt_ff;
   logic [HFP_CNTW-1:0] drop_ff;
   logic link_lat_ff;
   logic err_lat_ff;
   logic [HFP_LW-1:0] sz_rxd_ff;
   logic [HFP_LW-1:0] sz_txd_ff;
   logic [HFP_LW-1:0] sz_rxs_ff;
   logic rxfl_ff;
   logic txfl_ff;
   logic txd_v_ff;
   logic [HFP_DW-1:0] txd_d_ff;

   logic q_push [NQ];
   logic q_pop [NQ];
   logic [HFP_DW-1:0] q_wdata [NQ];
   logic [HFP_DW-1:0] q_head [NQ];
   logic [HFP_QAW:0] q_count [NQ];
   logic q_full [NQ];
   logic q_empty [NQ];
   logic q_flush [NQ];
   logic [HFP_QAW:0] q_limit [NQ];

   logic txd_load;
   logic rd_pop_port;
   logic rd_pop_empty;
   logic evt_rd;
   logic drop_rd;
   logic latch_rd;
   logic [HFP_EVT_W-1:0] evt_set;
   logic [HFP_EVT_W-1:0] evt_clr;
   logic any_drop;

   // Host strobes and halfword pairing, low half first
   assign rd_lo = i_host_cs && i_host_rd && !i_host_addr[1];
   assign rd_hi = i_host_cs && i_host_rd && i_host_addr[1];
   assign wr_lo = i_host_cs && i_host_wr && !i_host_addr[1];
   assign wr_hi = i_host_cs && i_host_wr && i_host_addr[1];
   assign widx = i_host_addr[7:2];
   assign in_rxd = (widx[5:3] == HFP_RXD_WIDX);
   assign in_txd = (widx[5:3] == HFP_TXD_WIDX);
   assign wr_word = {i_host_wdata, wr_hold_ff};
   assign any_rst = i_rst || soft_rst_ff;

   // Side effects of a register read happen with the low half
   assign evt_rd = rd_lo && (widx == HFP_EVT_REG[7:2]);
   assign drop_rd = rd_lo && (widx == HFP_DROP_REG[7:2]);
   assign latch_rd = rd_lo && (widx == HFP_LATCH_REG[7:2]);

   // Pop ports pop on the high half, after both halves left
   always_comb begin
      rd_pop_port = 1'b0;
      rd_pop_empty = 1'b0;
      for (int q = 0; q < NQ; q++) begin
         q_pop[q] = 1'b0;
      end
      if (rd_hi) begin
         if (in_rxd) begin
            q_pop[HFP_Q_RXD] = 1'b1;
            rd_pop_port = 1'b1;
            rd_pop_empty = q_empty[HFP_Q_RXD];
         end else if (widx == HFP_RXS_POP[7:2]) begin
            q_pop[HFP_Q_RXS] = 1'b1;
            rd_pop_port = 1'b1;
            rd_pop_empty = q_empty[HFP_Q_RXS];
         end else if (widx == HFP_TXS_POP[7:2]) begin
            q_pop[HFP_Q_TXS] = 1'b1;
            rd_pop_port = 1'b1;
            rd_pop_empty = q_empty[HFP_Q_TXS];
         end
      end
      q_pop[HFP_Q_TXD] = txd_load && !q_empty[HFP_Q_TXD];
   end

   // Read multiplexer for the low-half access
   always_comb begin
      rd_word = '0;
      if (in_rxd) begin
         rd_word = q_head[HFP_Q_RXD];
      end else if (in_txd) begin
         rd_word = '0;
      end else begin
         unique case (widx)
            HFP_RXS_POP[7:2], HFP_RXS_PEEK[7:2]: begin
               rd_word = q_head[HFP_Q_RXS];
            end
            HFP_TXS_POP[7:2], HFP_TXS_PEEK[7:2]: begin
               rd_word = q_head[HFP_Q_TXS];
            end
            HFP_TEST_REG[7:2]: rd_word = HFP_TEST_VAL;
            HFP_CMD_REG[7:2]: rd_word = '0;
            HFP_EVT_REG[7:2]: rd_word = {28'h0, evt_ff};
            HFP_DROP_REG[7:2]: rd_word = {16'h0, drop_ff};
            HFP_LATCH_REG[7:2]: rd_word = {30'h0, err_lat_ff, link_lat_ff};
            HFP_SIZE_REG[7:2]: begin
               rd_word[HFP_SZ_RXD +: HFP_LW] = sz_rxd_ff;
               rd_word[HFP_SZ_TXD +: HFP_LW] = sz_txd_ff;
               rd_word[HFP_SZ_RXS +: HFP_LW] = sz_rxs_ff;
            end
            HFP_LEVEL_REG[7:2]: begin
               rd_word[HFP_LV_RXD +: HFP_LW] = q_count[HFP_Q_RXD];
               rd_word[HFP_LV_TXD +: HFP_LW] = q_count[HFP_Q_TXD];
               rd_word[HFP_LV_RXS +: HFP_LW] = q_count[HFP_Q_RXS];
               rd_word[HFP_LV_TXS +: HFP_LW] = q_count[HFP_Q_TXS];
            end
            default: rd_word = '0;
         endcase
      end
   end

   // Host read data path
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_host_rdata <= '0;
         o_host_rvalid <= 1'b0;
         rd_snap_ff <= '0;
      end else begin
         o_host_rvalid <= rd_lo || rd_hi;
         if (rd_lo) begin
            rd_snap_ff <= rd_word;
            o_host_rdata <= rd_word[HFP_HW-1:0];
         end else if (rd_hi) begin
            o_host_rdata <= rd_snap_ff[HFP_DW-1:HFP_HW];
         end
      end
   end

   // Low half of a write waits for its partner
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_hold_ff <= '0;
      end else if (wr_lo) begin
         wr_hold_ff <= i_host_wdata;
      end
   end

   // Write-only commands, self clearing after one cycle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         soft_rst_ff <= 1'b0;
         rxfl_ff <= 1'b0;
         txfl_ff <= 1'b0;
         o_soft_rst <= 1'b0;
      end else begin
         soft_rst_ff <= 1'b0;
         rxfl_ff <= 1'b0;
         txfl_ff <= 1'b0;
         if (wr_hi && widx == HFP_CMD_REG[7:2]) begin
            soft_rst_ff <= wr_word[HFP_CMD_SRST];
            rxfl_ff <= wr_word[HFP_CMD_RXFL];
            txfl_ff <= wr_word[HFP_CMD_TXFL];
         end
         o_soft_rst <= wr_hi && widx == HFP_CMD_REG[7:2] &&
            wr_word[HFP_CMD_SRST];
      end
   end

   // Capacity fields survive a soft reset
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sz_rxd_ff <= HFP_SZ_RST;
         sz_txd_ff <= HFP_SZ_RST;
         sz_rxs_ff <= HFP_SZ_RST;
      end else if (wr_hi && widx == HFP_SIZE_REG[7:2]) begin
         sz_rxd_ff <= wr_word[HFP_SZ_RXD +: HFP_LW];
         sz_txd_ff <= wr_word[HFP_SZ_TXD +: HFP_LW];
         sz_rxs_ff <= wr_word[HFP_SZ_RXS +: HFP_LW];
      end
   end

   // Event flags: hardware set wins over the host clear
   always_comb begin
      evt_set = '0;
      evt_set[HFP_EVT_RXS_OVF] = i_rxs_push && q_full[HFP_Q_RXS];
      evt_set[HFP_EVT_RXD_OVF] = i_rxd_push && q_full[HFP_Q_RXD];
      evt_set[HFP_EVT_TXD_OVF] = q_push[HFP_Q_TXD] && q_full[HFP_Q_TXD];
      evt_set[HFP_EVT_UNDER] = rd_pop_port && rd_pop_empty;
      evt_clr = '0;
      if (wr_hi && widx == HFP_EVT_REG[7:2]) begin
         evt_clr = wr_word[HFP_EVT_W-1:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (any_rst) begin
         evt_ff <= '0;
      end else begin
         evt_ff <= (evt_ff & ~evt_clr) | evt_set;
      end
   end

   // Dropped-entry counter, cleared by reading it
   assign any_drop = |evt_set[HFP_EVT_TXD_OVF:HFP_EVT_RXS_OVF];

   always_ff @(posedge i_core_clk) begin
      if (any_rst) begin
         drop_ff <= '0;
      end else if (drop_rd) begin
         drop_ff <= {{(HFP_CNTW-1){1'b0}}, any_drop};
      end else if (any_drop && drop_ff != '1) begin
         drop_ff <= drop_ff + HFP_CNTW'(1);
      end
   end

   // Latched link-low and error-high indications
   always_ff @(posedge i_core_clk) begin
      if (any_rst) begin
         link_lat_ff <= 1'b1;
         err_lat_ff <= 1'b0;
      end else begin
         if (latch_rd) begin
            link_lat_ff <= i_link_up;
            err_lat_ff <= i_err_evt;
         end else begin
            link_lat_ff <= link_lat_ff && i_link_up;
            err_lat_ff <= err_lat_ff || i_err_evt;
         end
      end
   end

   // Queue inputs; writes to read-only ports are dropped
   always_comb begin
      q_push[HFP_Q_RXS] = i_rxs_push;
      q_push[HFP_Q_RXD] = i_rxd_push;
      q_push[HFP_Q_TXS] = i_txs_push;
      q_push[HFP_Q_TXD] = wr_hi && in_txd;
      q_wdata[HFP_Q_RXS] = i_rxs_data;
      q_wdata[HFP_Q_RXD] = i_rxd_data;
      q_wdata[HFP_Q_TXS] = i_txs_data;
      q_wdata[HFP_Q_TXD] = wr_word;
      q_flush[HFP_Q_RXS] = rxfl_ff;
      q_flush[HFP_Q_RXD] = rxfl_ff;
      q_flush[HFP_Q_TXS] = txfl_ff;
      q_flush[HFP_Q_TXD] = txfl_ff;
      q_limit[HFP_Q_RXS] = sz_rxs_ff;
      q_limit[HFP_Q_RXD] = sz_rxd_ff;
      q_limit[HFP_Q_TXS] = HFP_SZ_RST;
      q_limit[HFP_Q_TXD] = sz_txd_ff;
   end

   // The four host queues
   for (genvar g = 0; g < NQ; g++) begin : g_q
      hfp_queue #(
         .W(HFP_DW),
         .DEPTH(HFP_QDEPTH),
         .AW(HFP_QAW)
      ) u_q (
         .i_core_clk(i_core_clk),
         .i_rst(any_rst),
         .i_flush(q_flush[g]),
         .i_limit(q_limit[g]),
         .i_push(q_push[g]),
         .i_wdata(q_wdata[g]),
         .i_pop(q_pop[g]),
         .o_head(q_head[g]),
         .o_count(q_count[g]),
         .o_full(q_full[g]),
         .o_empty(q_empty[g])
      );
   end

   // Transmit data output stage toward the MAC
   assign txd_load = !txd_v_ff || i_txd_ready;

   always_ff @(posedge i_core_clk) begin
      if (any_rst || txfl_ff) begin
         txd_v_ff <= 1'b0;
         txd_d_ff <= '0;
      end else if (txd_load) begin
         txd_v_ff <= !q_empty[HFP_Q_TXD];
         txd_d_ff <= q_head[HFP_Q_TXD];
      end
   end

   assign o_txd_valid = txd_v_ff;
   assign o_txd_data = txd_d_ff;

   // Queue full flags, registered once more here after each queue's own flag
   always_ff @(posedge i_core_clk) begin
      if (any_rst) begin
         o_rxs_full <= 1'b0;
         o_rxd_full <= 1'b0;
         o_txs_full <= 1'b0;
      end else begin
         o_rxs_full <= q_full[HFP_Q_RXS];
         o_rxd_full <= q_full[HFP_Q_RXD];
         o_txs_full <= q_full[HFP_Q_TXS];
      end
   end
endmodule

// *** bench/hfp_checker.sv ***
// Assertions on the host port side of the queue block
`timescale 1ns/1ns
module hfp_checker (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_host_cs,
   input wire logic i_host_rd,
   input wire logic i_host_wr,
   input wire logic [7:1] i_host_addr,
   input wire logic [hfp_pkg::HFP_HW-1:0] o_host_rdata,
   input wire logic o_host_rvalid,
   input wire logic o_txd_valid,
   input wire logic [hfp_pkg::HFP_DW-1:0] o_txd_data,
   input wire logic i_txd_ready,
   input wire logic o_soft_rst
);
   import hfp_pkg::*;
   localparam logic [7:1] CMD_A = HFP_CMD_REG[7:1];
   localparam logic [7:1] TEST_A = HFP_TEST_REG[7:1];
   logic rd_s;
   logic cmd_hi;
   assign rd_s = i_host_cs & i_host_rd;
   assign cmd_hi = i_host_cs & i_host_wr & (i_host_addr == (CMD_A | 7'h01));
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   rvalid_cause_a: assert property (rd_s |=> o_host_rvalid)
      else $error("read got no answer");
   rvalid_idle_a: assert property (!rd_s |=> !o_host_rvalid)
      else $error("answer without a read");
   rdata_hold_a: assert property (
      !rd_s |=> $stable(o_host_rdata))
      else $error("read data moved without a read");
   wo_zero_a: assert property (
      rd_s && i_host_addr[7:2] == CMD_A[7:2] |=> o_host_rdata == 16'h0000)
      else $error("write-only register read nonzero");
   ro_low_a: assert property (
      rd_s && i_host_addr == TEST_A |=> o_host_rdata == HFP_TEST_VAL[15:0])
      else $error("test pattern low half wrong");
   ro_high_a: assert property (
      rd_s && i_host_addr == (TEST_A | 7'h01)
      |=> o_host_rdata == HFP_TEST_VAL[31:16])
      else $error("test pattern high half wrong");
   txd_noread_a: assert property (
      rd_s && i_host_addr[7:5] == 3'b001 |=> o_host_rdata == 16'h0000)
      else $error("tx data window returned data");
   txd_hold_a: assert property (
      o_txd_valid && !i_txd_ready && !o_soft_rst
      |=> o_soft_rst || (o_txd_valid && $stable(o_txd_data)))
      else $error("tx word dropped or changed while stalled");
   srst_pulse_a: assert property (o_soft_rst |=> !o_soft_rst)
      else $error("soft reset longer than one cycle");
   srst_cause_a: assert property (
      o_soft_rst |-> $past(cmd_hi) || $past(cmd_hi, 2))
      else $error("soft reset without command write");

   cover property (rd_s && i_host_addr == HFP_RXS_PEEK[7:1]);
   cover property (o_txd_valid && i_txd_ready);
   cover property (o_soft_rst);
endmodule

// *** bench/hfp_host_model.sv ***
// Host CPU model: 16-bit strobed accesses paired into words
`timescale 1ns/1ns
module hfp_host_model (
   input wire logic i_core_clk,
   input wire logic [hfp_pkg::HFP_HW-1:0] i_rdata,
   input wire logic i_rvalid,
   output logic o_cs,
   output logic o_rd,
   output logic o_wr,
   output logic [7:1] o_addr,
   output logic [hfp_pkg::HFP_HW-1:0] o_wdata,
   output logic o_lost
);
   import hfp_pkg::*;
   initial begin
      {o_cs, o_rd, o_wr, o_addr, o_wdata, o_lost} = '0;
   end
   // Callers reach mapped places and the reserved 8'h6C, reserved bits zero
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      {o_cs, o_rd, o_wr, o_addr, o_wdata} <= {3'b101, a[7:1], d};
      @(posedge i_core_clk);
      {o_cs, o_rd, o_wr, o_addr, o_wdata} <= {3'b000, ~a[7:1], ~d};
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      {o_cs, o_rd, o_wr, o_addr} <= {3'b110, a[7:1]};
      @(posedge i_core_clk);
      {o_cs, o_rd, o_wr, o_addr} <= {3'b000, ~a[7:1]};
      do begin
         @(posedge i_core_clk);
         n++;
      end while (i_rvalid !== 1'b1 && n < 4);
      if (i_rvalid !== 1'b1)
         o_lost <= 1'b1;
      d = i_rdata;
   endtask
   // Low half first, high half commits or pops
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      wr16(a, d[15:0]);
      wr16(a | 8'h02, d[31:16]);
   endtask
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      rd16(a, d[15:0]);
      rd16(a | 8'h02, d[31:16]);
   endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the host queue ports
`timescale 1ns/1ns
module tb;
   import hfp_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic host_cs, host_rd, host_wr, host_lost;
   logic [7:1] host_addr;
   logic [HFP_HW-1:0] host_wdata, o_host_rdata;
   logic o_host_rvalid, o_rxs_full, o_rxd_full, o_txs_full;
   logic o_txd_valid, o_soft_rst;
   logic i_txd_ready = 1'b0;
   logic i_link_up = 1'b1;
   logic i_err_evt = 1'b0;
   logic [2:0] mpush = 3'b000;
   logic [31:0] mdata = 32'h0;
   logic [31:0] o_txd_data, tx_exp;
   logic [31:0] txd_q[$];
   int errors = 0;
   int n_tests = 0;

   hfp_top i_hfp_top (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_host_cs(host_cs),
      .i_host_rd(host_rd), .i_host_wr(host_wr), .i_host_addr(host_addr),
      .i_host_wdata(host_wdata), .o_host_rdata(o_host_rdata),
      .o_host_rvalid(o_host_rvalid), .i_rxs_push(mpush[0]),
      .i_rxs_data(mdata), .o_rxs_full(o_rxs_full), .i_rxd_push(mpush[1]),
      .i_rxd_data(mdata), .o_rxd_full(o_rxd_full), .i_txs_push(mpush[2]),
      .i_txs_data(mdata), .o_txs_full(o_txs_full),
      .o_txd_valid(o_txd_valid), .o_txd_data(o_txd_data),
      .i_txd_ready(i_txd_ready), .i_link_up(i_link_up),
      .i_err_evt(i_err_evt), .o_soft_rst(o_soft_rst));
   hfp_host_model i_hfp_host_model (
      .i_core_clk(i_core_clk), .i_rdata(o_host_rdata),
      .i_rvalid(o_host_rvalid), .o_cs(host_cs), .o_rd(host_rd),
      .o_wr(host_wr), .o_addr(host_addr), .o_wdata(host_wdata),
      .o_lost(host_lost));

   always #25 i_core_clk = ~i_core_clk;
   // Far side stalls one cycle in four
   always @(posedge i_core_clk)
      i_txd_ready <= ($urandom % 4) != 0;
   always @(posedge i_core_clk)
      if (o_txd_valid === 1'b1 && i_txd_ready === 1'b1) begin
         tx_exp = txd_q.size() > 0 ? txd_q.pop_front() : ~o_txd_data;
         chk("tx word", tx_exp, o_txd_data);
      end
   always @(posedge i_core_clk)
      if (host_lost === 1'b1) begin
         errors++;
         wrap_up();
      end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
      logic [31:0] g;
      i_hfp_host_model.rd32(a, g);
      chk(nm, e, g);
   endtask
   task automatic mpush_w(input int k, input logic [31:0] d);
      @(posedge i_core_clk);
      mpush <= 3'(1 << k);
      mdata <= d;
      @(posedge i_core_clk);
      mpush <= 3'b000;
      mdata <= ~d;
   endtask
   task automatic wrap_up();
      if (errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      logic [31:0] w;
      logic [31:0] sq[$];
      logic [7:0] pk, pp;
      int n;
      void'($urandom(27));
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      i_hfp_host_model.wr32(HFP_TEST_REG, $urandom);
      rchk("test reg", HFP_TEST_REG, HFP_TEST_VAL);
      i_hfp_host_model.wr32(HFP_CMD_REG, 32'h1 << HFP_CMD_TXFL);
      rchk("command", HFP_CMD_REG, 32'h0);
      rchk("reserved", 8'h6C, 32'h0);
      for (int k = 0; k < 2; k++) begin
         pk = k ? HFP_TXS_PEEK : HFP_RXS_PEEK;
         pp = k ? HFP_TXS_POP : HFP_RXS_POP;
         repeat (3) begin
            w = $urandom;
            mpush_w(2 * k, w);
            sq.push_back(w);
         end
         rchk("peek", pk, sq[0]);
         rchk("peek again", pk, sq[0]);
         while (sq.size() > 0)
            rchk("pop", pp, sq.pop_front());
      end
      i_hfp_host_model.rd32(HFP_RXS_POP, w);
      rchk("events", HFP_EVT_REG, 32'h1 << HFP_EVT_UNDER);
      i_hfp_host_model.wr32(HFP_EVT_REG, 32'h0);
      rchk("events kept", HFP_EVT_REG, 32'h1 << HFP_EVT_UNDER);
      i_hfp_host_model.wr32(HFP_EVT_REG, 32'h1 << HFP_EVT_UNDER);
      rchk("events cleared", HFP_EVT_REG, 32'h0);
      for (int i = 0; i < 8; i++) begin
         w = $urandom;
         mpush_w(1, w);
         sq.push_back(w);
      end
      for (int i = 0; i < 8; i++) begin
         pk = HFP_RXD_BASE + 8'(4 * i);
         rchk("rx data", pk, sq.pop_front());
      end
      rchk("levels", HFP_LEVEL_REG, 32'h0);
      for (int i = 0; i < 8; i++) begin
         w = $urandom;
         pk = HFP_TXD_BASE + 8'(4 * i);
         txd_q.push_back(w);
         i_hfp_host_model.wr32(pk, w);
      end
      rchk("tx window", HFP_TXD_BASE, 32'h0);
      n = 0;
      while (txd_q.size() > 0 && n < 200) begin
         @(posedge i_core_clk);
         n++;
      end
      chk("tx drained", 32'h0, 32'(txd_q.size()));
      if (txd_q.size() > 0)
         wrap_up();
      i_hfp_host_model.wr32(HFP_SIZE_REG, 32'h0002_1010);
      rchk("size", HFP_SIZE_REG, 32'h0002_1010);
      repeat (3) mpush_w(0, $urandom);
      repeat (2) @(posedge i_core_clk);
      chk("rx status full", 32'h1, 32'(o_rxs_full));
      rchk("drops", HFP_DROP_REG, 32'h1);
      rchk("drops again", HFP_DROP_REG, 32'h0);
      rchk("overflow", HFP_EVT_REG, 32'h1 << HFP_EVT_RXS_OVF);
      @(posedge i_core_clk);
      i_link_up <= 1'b0;
      i_err_evt <= 1'b1;
      @(posedge i_core_clk);
      i_link_up <= 1'b1;
      i_err_evt <= 1'b0;
      rchk("latched", HFP_LATCH_REG, 32'h1 << HFP_LAT_ERR);
      rchk("rearmed", HFP_LATCH_REG, 32'h1 << HFP_LAT_LINK);
      i_hfp_host_model.wr32(HFP_CMD_REG, 32'h1 << HFP_CMD_SRST);
      n = 0;
      while (o_soft_rst !== 1'b1 && n < 8) begin
         @(posedge i_core_clk);
         n++;
      end
      chk("soft reset", 32'h1, 32'(o_soft_rst));
      if (o_soft_rst !== 1'b1)
         wrap_up();
      rchk("size kept", HFP_SIZE_REG, 32'h0002_1010);
      rchk("events reset", HFP_EVT_REG, 32'h0);
      rchk("levels reset", HFP_LEVEL_REG, 32'h0);
      @(posedge i_core_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rchk("size default", HFP_SIZE_REG, 32'h0010_1010);
      repeat (16) mpush_w(1, $urandom);
      repeat (16) mpush_w(2, $urandom);
      repeat (2) @(posedge i_core_clk);
      chk("rx data full", 32'h1, 32'(o_rxd_full));
      chk("tx status full", 32'h1, 32'(o_txs_full));
      rchk("levels full", HFP_LEVEL_REG, 32'h1000_0010);
      wrap_up();
   end
endmodule

bind hfp_top hfp_checker i_hfp_checker (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_host_cs(i_host_cs),
   .i_host_rd(i_host_rd), .i_host_wr(i_host_wr),
   .i_host_addr(i_host_addr), .o_host_rdata(o_host_rdata),
   .o_host_rvalid(o_host_rvalid), .o_txd_valid(o_txd_valid),
   .o_txd_data(o_txd_data), .i_txd_ready(i_txd_ready),
   .o_soft_rst(o_soft_rst));
